// File: core/sbp_basic_param_rom.v
// Function
// - host selects byte with low 8 address bits after 5Ah; 8 dummy clocks follow
// - data shifts out on falling clock edges, MSB first, after the dummy clocks
// - table served here starts at discovery offset 80h
// - byte 80h reads E5h: 4KB erase, large program buffer, top bits ones
// - byte 81h reads 20h, the uniform 4KB erase opcode
// - byte 82h reads F1h: quad/dual read support flags, no double data rate
// - byte 83h is unused and reads FFh
// - byte 88h reads 44h: two mode, four dummy cycles for quad I/O
// - byte 89h reads EBh, the quad I/O read opcode
// - byte 8Ah reads 08h: eight dummy cycles for quad output read
// - byte 8Bh reads 6Bh, the quad output read opcode
// - byte 8Ch reads 08h: eight dummy cycles for dual output read
// - byte 8Dh reads 3Bh, the dual output read opcode
// - byte 8Eh reads 40h: two mode cycles, zero dummy for dual I/O
// - byte 8Fh reads BBh, the dual I/O read opcode
// - byte 90h reads EEh: no four-lane or two-lane all-phase modes
// - bytes 91h to 93h are reserved and read FFh
`timescale 1ns/100ps
`include "sbp_regs.vh"

module sbp_basic_param_rom (
  // system
  input wire CLOCK,
  input wire RESET,
  // serial pins from the host
  input wire SPI_CS_N,
  input wire SPI_CLK,
  input wire SPI_DI,
  // serial data pin back to the host
  output reg SPI_DO,
  output reg SPI_DO_OE
);

  // ==========================================================
  // states
  localparam [4:0] ST_CMD = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_DUMMY = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_IGNORE = 5'h10;

  // ==========================================================
  // constant table lookup
  // contents are plain constants; no path from any pin reaches them
  function [7:0] table_byte;
    input [7:0] ofs;
    begin
      case (ofs)
        `SBP_OFS_ERASE_AND_BUFFER_CAPS: table_byte = `SBP_VAL_ERASE_AND_BUFFER_CAPS;
        `SBP_OFS_SMALL_ERASE_OPCODE: table_byte = `SBP_VAL_SMALL_ERASE_OPCODE;
        `SBP_OFS_READ_MODE_SUPPORT_FLAGS: table_byte = `SBP_VAL_READ_MODE_SUPPORT_FLAGS;
        `SBP_OFS_FIRST_DWORD_UNUSED_BYTE: table_byte = `SBP_VAL_FIRST_DWORD_UNUSED_BYTE;
        `SBP_OFS_DENSITY_BYTE0: table_byte = `SBP_VAL_DENSITY_BYTE0;
        `SBP_OFS_DENSITY_BYTE1: table_byte = `SBP_VAL_DENSITY_BYTE1;
        `SBP_OFS_DENSITY_BYTE2: table_byte = `SBP_VAL_DENSITY_BYTE2;
        `SBP_OFS_DENSITY_BYTE3: table_byte = `SBP_VAL_DENSITY_BYTE3;
        `SBP_OFS_QUAD_IO_CYCLE_COUNTS: table_byte = `SBP_VAL_QUAD_IO_CYCLE_COUNTS;
        `SBP_OFS_QUAD_IO_READ_OPCODE: table_byte = `SBP_VAL_QUAD_IO_READ_OPCODE;
        `SBP_OFS_QUAD_OUT_CYCLE_COUNTS: table_byte = `SBP_VAL_QUAD_OUT_CYCLE_COUNTS;
        `SBP_OFS_QUAD_OUT_READ_OPCODE: table_byte = `SBP_VAL_QUAD_OUT_READ_OPCODE;
        `SBP_OFS_DUAL_OUT_CYCLE_COUNTS: table_byte = `SBP_VAL_DUAL_OUT_CYCLE_COUNTS;
        `SBP_OFS_DUAL_OUT_READ_OPCODE: table_byte = `SBP_VAL_DUAL_OUT_READ_OPCODE;
        `SBP_OFS_DUAL_IO_CYCLE_COUNTS: table_byte = `SBP_VAL_DUAL_IO_CYCLE_COUNTS;
        `SBP_OFS_DUAL_IO_READ_OPCODE: table_byte = `SBP_VAL_DUAL_IO_READ_OPCODE;
        `SBP_OFS_ALL_LANE_MODE_SUPPORT: table_byte = `SBP_VAL_ALL_LANE_MODE_SUPPORT;
        `SBP_OFS_FIFTH_DWORD_RESERVED1: table_byte = `SBP_VAL_RESERVED_FUTURE_BITS;
        `SBP_OFS_FIFTH_DWORD_RESERVED2: table_byte = `SBP_VAL_RESERVED_FUTURE_BITS;
        `SBP_OFS_FIFTH_DWORD_RESERVED3: table_byte = `SBP_VAL_RESERVED_FUTURE_BITS;
        // bytes outside this slice belong to other tables
        default: table_byte = `SBP_FILL_BYTE;
      endcase
    end
  endfunction

  // ==========================================================
  // pin synchronisers, three stages each
  reg [2:0] cs_sync;
  reg [2:0] clk_sync;
  reg [2:0] di_sync;
  reg cs_n;
  reg sclk;
  reg din;

  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      cs_sync <= 3'h7;
      clk_sync <= 3'h0;
      di_sync <= 3'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], SPI_CS_N};
      clk_sync <= {clk_sync[1:0], SPI_CLK};
      di_sync <= {di_sync[1:0], SPI_DI};
    end
  end

  // a level is accepted only once stages two and three agree
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      cs_n <= 1'b1;
      sclk <= 1'b0;
      din <= 1'b0;
    end else begin
      if (cs_sync[1] == cs_sync[2]) begin
        cs_n <= cs_sync[2];
      end
      if (clk_sync[1] == clk_sync[2]) begin
        sclk <= clk_sync[2];
      end
      if (di_sync[1] == di_sync[2]) begin
        din <= di_sync[2];
      end
    end
  end

  // sclk and cs_n are already filtered, so the edge test reads settled levels
  wire sclk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !sclk;
  wire sclk_fall = (clk_sync[1] == clk_sync[2]) && !clk_sync[2] && sclk;
  // data is taken from the settled stage as the edge is accepted
  wire din_now = (di_sync[1] == di_sync[2]) ? di_sync[2] : din;

  // ==========================================================
  // command sequencer
  reg [4:0] state;
  reg [5:0] bit_cnt;
  reg [7:0] in_sr;
  reg [7:0] rd_addr;
  reg [7:0] out_sr;
  reg [2:0] out_bit;
  reg [7:0] next_byte;

  always @* begin
    next_byte = table_byte(rd_addr);
  end

  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state <= ST_CMD;
      bit_cnt <= 6'h00;
      in_sr <= 8'h00;
      rd_addr <= 8'h00;
      out_sr <= 8'h00;
      out_bit <= 3'h0;
      SPI_DO <= 1'b0;
      SPI_DO_OE <= 1'b0;
    end else if (cs_n) begin
      // deselect ends any frame and releases the pin
      state <= ST_CMD;
      bit_cnt <= 6'h00;
      out_bit <= 3'h0;
      SPI_DO_OE <= 1'b0;
    end else if (sclk_rise) begin
      in_sr <= {in_sr[6:0], din_now};
      case (state)
        ST_CMD: begin
          if (bit_cnt == `SBP_CMD_BITS - 6'd1) begin
            bit_cnt <= 6'h00;
            if ({in_sr[6:0], din_now} == `SBP_CMD_DISCOVERY_READ) begin
              state <= ST_ADDR;
            end else begin
              // other instructions are not served by this block
              state <= ST_IGNORE;
            end
          end else begin
            bit_cnt <= bit_cnt + 6'd1;
          end
        end
        ST_ADDR: begin
          if (bit_cnt == `SBP_ADDR_BITS - 6'd1) begin
            // upper sixteen bits are zero by protocol and are not checked
            rd_addr <= {in_sr[6:0], din_now};
            bit_cnt <= 6'h00;
            state <= ST_DUMMY;
          end else begin
            bit_cnt <= bit_cnt + 6'd1;
          end
        end
        ST_DUMMY: begin
          if (bit_cnt == `SBP_DUMMY_BITS - 6'd1) begin
            bit_cnt <= 6'h00;
            state <= ST_DATA;
          end else begin
            bit_cnt <= bit_cnt + 6'd1;
          end
        end
        ST_DATA: begin
          // input bits during data out carry no meaning
          state <= ST_DATA;
        end
        ST_IGNORE: begin
          state <= ST_IGNORE;
        end
        default: begin
          state <= ST_CMD;
        end
      endcase
    end else if (sclk_fall && (state == ST_DATA)) begin
      SPI_DO_OE <= 1'b1;
      if (out_bit == 3'h0) begin
        SPI_DO <= next_byte[7];
        out_sr <= {next_byte[6:0], 1'b0};
      end else begin
        SPI_DO <= out_sr[7];
        out_sr <= {out_sr[6:0], 1'b0};
      end
      out_bit <= out_bit + 3'h1;
      // reads stream on; the byte address wraps within the 256-byte space
      if (out_bit == 3'h7) begin
        rd_addr <= rd_addr + 8'h01;
      end
    end
  end

endmodule // sbp_basic_param_rom

// File: core/sbp_regs.vh
`ifndef SBP_REGS_VH
`define SBP_REGS_VH

// ==========================================================
// serial command framing
`define SBP_CMD_DISCOVERY_READ 8'h5A
`define SBP_CMD_BITS 6'd8
`define SBP_ADDR_BITS 6'd24
`define SBP_DUMMY_BITS 6'd8
`define SBP_FILL_BYTE 8'hFF

// ==========================================================
// basic parameter table offsets
`define SBP_OFS_ERASE_AND_BUFFER_CAPS 8'h80
`define SBP_OFS_SMALL_ERASE_OPCODE 8'h81
`define SBP_OFS_READ_MODE_SUPPORT_FLAGS 8'h82
`define SBP_OFS_FIRST_DWORD_UNUSED_BYTE 8'h83
`define SBP_OFS_DENSITY_BYTE0 8'h84
`define SBP_OFS_DENSITY_BYTE1 8'h85
`define SBP_OFS_DENSITY_BYTE2 8'h86
`define SBP_OFS_DENSITY_BYTE3 8'h87
`define SBP_OFS_QUAD_IO_CYCLE_COUNTS 8'h88
`define SBP_OFS_QUAD_IO_READ_OPCODE 8'h89
`define SBP_OFS_QUAD_OUT_CYCLE_COUNTS 8'h8A
`define SBP_OFS_QUAD_OUT_READ_OPCODE 8'h8B
`define SBP_OFS_DUAL_OUT_CYCLE_COUNTS 8'h8C
`define SBP_OFS_DUAL_OUT_READ_OPCODE 8'h8D
`define SBP_OFS_DUAL_IO_CYCLE_COUNTS 8'h8E
`define SBP_OFS_DUAL_IO_READ_OPCODE 8'h8F
`define SBP_OFS_ALL_LANE_MODE_SUPPORT 8'h90
`define SBP_OFS_FIFTH_DWORD_RESERVED1 8'h91
`define SBP_OFS_FIFTH_DWORD_RESERVED2 8'h92
`define SBP_OFS_FIFTH_DWORD_RESERVED3 8'h93

// ==========================================================
// fixed table contents
`define SBP_VAL_ERASE_AND_BUFFER_CAPS 8'hE5
`define SBP_VAL_SMALL_ERASE_OPCODE 8'h20
`define SBP_VAL_READ_MODE_SUPPORT_FLAGS 8'hF1
`define SBP_VAL_FIRST_DWORD_UNUSED_BYTE 8'hFF
`define SBP_VAL_DENSITY_BYTE0 8'hFF
`define SBP_VAL_DENSITY_BYTE1 8'hFF
`define SBP_VAL_DENSITY_BYTE2 8'hFF
`define SBP_VAL_DENSITY_BYTE3 8'h03
`define SBP_VAL_QUAD_IO_CYCLE_COUNTS 8'h44
`define SBP_VAL_QUAD_IO_READ_OPCODE 8'hEB
`define SBP_VAL_QUAD_OUT_CYCLE_COUNTS 8'h08
`define SBP_VAL_QUAD_OUT_READ_OPCODE 8'h6B
`define SBP_VAL_DUAL_OUT_CYCLE_COUNTS 8'h08
`define SBP_VAL_DUAL_OUT_READ_OPCODE 8'h3B
`define SBP_VAL_DUAL_IO_CYCLE_COUNTS 8'h40
`define SBP_VAL_DUAL_IO_READ_OPCODE 8'hBB
`define SBP_VAL_ALL_LANE_MODE_SUPPORT 8'hEE
`define SBP_VAL_RESERVED_FUTURE_BITS 8'hFF

`endif

// File: tb/sbp_basic_param_rom_bench.sv
`timescale 1ns/100ps
`define CHK(a, b, m) begin samples_checked = samples_checked + 1; if ((a) !== (b)) begin err_total = err_total + 1; $display("mismatch %0t %s", $time, m); end end
module sbp_basic_param_rom_bench;
  localparam [159:0] TBL = 160'hE520F1FF_FFFFFF03_44EB086B_083B40BB_EEFFFFFF;
  reg CLOCK = 1'b0;
  reg RESET = 1'b1;
  reg last_do = 1'b0;
  wire cs_n, sck, mosi, do_pin, oe;
  // released line shows the inverse of its last value
  wire line = oe ? do_pin : ~last_do;
  integer err_total = 0, samples_checked = 0, cyc = 0, i, k;
  reg [31:0] seed = 32'h00010D3C;
  reg [7:0] r, op;
  sbp_basic_param_rom sbp_basic_param_rom_inst (.CLOCK(CLOCK), .RESET(RESET), .SPI_CS_N(cs_n), .SPI_CLK(sck),
    .SPI_DI(mosi), .SPI_DO(do_pin), .SPI_DO_OE(oe));
  sbp_host_model sbp_host_model_inst (.clock(CLOCK), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(line));
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function [7:0] expect_byte(input [7:0] o);
    expect_byte = (o >= 8'h80 && o < 8'h94) ? TBL[159 - 8 * (o - 8'h80) -: 8] : 8'hFF;
  endfunction
  task rd(input [7:0] ad, input integer n);
    begin
      seed = xs(seed);
      sbp_host_model_inst.cmd(8'h5A, ad, seed[7:0]);
      for (k = 0; k < n; k = k + 1) begin
        seed = xs(seed);
        sbp_host_model_inst.xfer(seed[7:0], r);
        `CHK(r, expect_byte(ad + k[7:0]), "table byte")
      end
      sbp_host_model_inst.stop;
    end
  endtask
  task summarize;
    begin
      $display("compares %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial forever #10 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (oe) last_do <= do_pin;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      summarize;
    end
  end
  initial begin
    repeat (5) @(negedge CLOCK);
    RESET = 1'b0;
    repeat (5) @(negedge CLOCK);
    rd(8'h80, 22);
    rd(8'hFE, 3);
    $display("test stream done");
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      rd(8'h80 + seed[7:0] % 8'h14, 1 + seed[9:8]);
    end
    $display("test random done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      op = (i == 0) ? 8'h02 : ((seed[7:0] == 8'h5A) ? 8'h5B : seed[7:0]);
      sbp_host_model_inst.cmd(op, 8'h80, seed[15:8]);
      for (k = 0; k < 2; k = k + 1) begin
        sbp_host_model_inst.xfer(seed[23:16], r);
        `CHK(oe, 1'b0, "refused opcode drove data")
      end
      sbp_host_model_inst.stop;
    end
    rd(8'h80, 20);
    $display("test refused done");
    sbp_host_model_inst.start;
    sbp_host_model_inst.xfer(8'h5A, r);
    sbp_host_model_inst.xfer(8'h00, r);
    sbp_host_model_inst.stop;
    rd(8'h8E, 3);
    $display("test abort done");
    RESET = 1'b1;
    repeat (2) @(negedge CLOCK);
    RESET = 1'b0;
    repeat (5) @(negedge CLOCK);
    `CHK(oe, 1'b0, "enable after reset")
    rd(8'h90, 4);
    $display("test reset done");
    summarize;
  end
endmodule // sbp_basic_param_rom_bench

// File: tb/sbp_basic_param_rom_sva.sv
`timescale 1ns/100ps
// ==========================================
// checker on the serial pins
module sbp_basic_param_rom_sva (
  // system
  input wire CLOCK,
  input wire RESET,
  // serial pins
  input wire SPI_CS_N,
  input wire SPI_CLK,
  input wire SPI_DI,
  input wire SPI_DO,
  input wire SPI_DO_OE
);
  reg sclk_q;
  reg [5:0] rises;
  reg [7:0] op;
  // counted at the pins, ahead of the design's synchronised view
  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      sclk_q <= 1'b0;
      rises <= 6'h00;
      op <= 8'h00;
    end else begin
      sclk_q <= SPI_CLK;
      if (SPI_CS_N) begin
        rises <= 6'h00;
      end else if (SPI_CLK && !sclk_q && rises != 6'h3F) begin
        rises <= rises + 6'h01;
        if (rises < 6'h08) begin
          op <= {op[6:0], SPI_DI};
        end
      end
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_cmd_ok;
    rises == 6'h28 && op == 8'h5A && $fell(SPI_CLK);
  endsequence
  a_oe_at_forty: assert property (s_cmd_ok |-> ##[1:7] SPI_DO_OE) else $error("no data after dummy");
  a_oe_before_forty: assert property (rises != 6'h00 && rises < 6'h28 |-> !SPI_DO_OE) else $error("early data");
  a_refused_op: assert property (rises >= 6'h08 && op != 8'h5A |-> !SPI_DO_OE) else $error("bad opcode served");
  a_do_change_low: assert property ($changed(SPI_DO) |-> !SPI_CLK && !SPI_CS_N) else $error("data moved off fall");
  a_do_stable_high: assert property (SPI_CLK [*2] |-> $stable(SPI_DO)) else $error("data moved in high phase");
  a_oe_rise_low: assert property ($rose(SPI_DO_OE) |-> !SPI_CLK && !SPI_CS_N) else $error("enable rose badly");
  a_oe_holds: assert property (SPI_DO_OE && !SPI_CS_N |=> SPI_DO_OE) else $error("enable dropped in frame");
  a_oe_idle: assert property (SPI_CS_N [*6] |-> !SPI_DO_OE) else $error("driving while deselected");
endmodule // sbp_basic_param_rom_sva
bind sbp_basic_param_rom sbp_basic_param_rom_sva sbp_basic_param_rom_sva_inst (.CLOCK(CLOCK), .RESET(RESET),
  .SPI_CS_N(SPI_CS_N), .SPI_CLK(SPI_CLK), .SPI_DI(SPI_DI), .SPI_DO(SPI_DO), .SPI_DO_OE(SPI_DO_OE));

// File: tb/sbp_host_model.sv
`timescale 1ns/100ps
// ==========================================
// host side of the serial link
module sbp_host_model (
  // system
  input wire clock,
  // serial pins
  output reg cs_n,
  output reg sck,
  output reg mosi,
  input wire miso
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // six periods a phase clears the design's synchroniser margin
  task half;
    repeat (6) @(negedge clock);
  endtask
  task start;
    cs_n <= 1'b0;
    half;
  endtask
  task stop;
    half;
    cs_n <= 1'b1;
    half;
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      mosi <= tx[i];
      half;
      rx[i] = miso;
      sck <= 1'b1;
      half;
      sck <= 1'b0;
    end
  endtask
  task cmd(input [7:0] op, input [7:0] ad, input [7:0] fill);
    reg [7:0] r;
    start;
    xfer(op, r);
    xfer(8'h00, r);
    xfer(8'h00, r);
    xfer(ad, r);
    xfer(fill, r);
  endtask
endmodule // sbp_host_model
